// >>> core/oms_pkg.sv
// Overview of operation
// - fault pin low normally, high on laser fault
// - light only while shutoff input is low
// - presence pin held to ground by module
// - one definition pin clock, one data
// - signal-lost output high when optical input lost
// - identification and live diagnostics readable over bus
// - diagnostics offered calibrated internally and externally
// - fault output raised within 100 us
// - transmitter off within 10 us of shutoff
// - transmitter restored within 1 ms of release
// - initialisation, fault clear included, within 300 ms
package oms_pkg;
   localparam int CLK_FREQ_MHZ = 10;
   localparam int SCL_MAX_KHZ  = 400;
   localparam int T_FAULT_US   = 100;
   localparam int T_OFF_US     = 10;
   localparam int T_ON_MS      = 1;
   localparam int T_INIT_MS    = 300;
   localparam int T_RESET_US   = 10;
   // longest times round down, least time is already whole
   localparam int FAULT_CYC    = T_FAULT_US * CLK_FREQ_MHZ;
   localparam int OFF_CYC      = T_OFF_US * CLK_FREQ_MHZ;
   localparam int ON_CYC       = T_ON_MS * 1000 * CLK_FREQ_MHZ;
   localparam int INIT_CYC     = T_INIT_MS * 1000 * CLK_FREQ_MHZ;
   localparam int RESET_CYC    = T_RESET_US * CLK_FREQ_MHZ;
   localparam int RST_CNT_W    = 8;

   localparam int NUM_MON      = 5;
   localparam int MON_W        = 16;
   localparam int ADDR_W       = 8;
   localparam int DATA_W       = 8;
   localparam int CAL_SHIFT    = 8;
   localparam int ID_LEN       = 16;

   // value is arbitrary
   localparam logic [6:0] TARGET_ADDR = 7'h2A;

   localparam logic [ADDR_W-1:0] CAL_BASE    = 8'h60;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h6E;
   localparam logic [ADDR_W-1:0] RAW_BASE    = 8'h70;
   localparam logic [ADDR_W-1:0] COEF_BASE   = 8'h80;

   localparam int ST_FAULT_BIT = 0;
   localparam int ST_LOST_BIT  = 1;
   localparam int ST_TXON_BIT  = 2;
   localparam int ST_INIT_BIT  = 3;

   // identification bytes; contents are arbitrary
   localparam logic [0:ID_LEN-1][DATA_W-1:0] ID_ROM = {
      8'h03, 8'h04, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h01, 8'h19, 8'h50, 8'h00, 8'h00};

   // unity slope in 8.8 fixed point, zero offset
   localparam logic [0:NUM_MON-1][MON_W-1:0] CAL_SLOPE = {
      16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100};
   localparam logic [0:NUM_MON-1][MON_W-1:0] CAL_OFFSET = {
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_ADDR = 3'b001,
      I2C_AACK = 3'b010,
      I2C_PTR  = 3'b011,
      I2C_PACK = 3'b100,
      I2C_TX   = 3'b101,
      I2C_MACK = 3'b110
   } oms_i2c_state_t;
endpackage : oms_pkg

// >>> core/oms_i2c_target.sv
`timescale 1ns/1ps
module oms_i2c_target #(
   parameter logic [6:0] TARGET_ADDR = oms_pkg::TARGET_ADDR
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_b,
   input  wire logic                        sclIn,
   input  wire logic                        sdaIn,
   output logic                             sdaOut,
   output logic                             sdaOe,
   output logic [oms_pkg::ADDR_W-1:0]       rdAddr,
   input  wire logic [oms_pkg::DATA_W-1:0]  rdData
);
   import oms_pkg::*;

   oms_i2c_state_t        state_q;
   logic                  sclQ;
   logic                  sdaQ;
   logic [DATA_W-1:0]     shift_q;
   logic [DATA_W-1:0]     tx_q;
   logic [2:0]            cnt_q;
   logic                  byteDone_q;
   logic                  rw_q;
   logic                  wrSeen_q;
   logic                  mAck_q;
   logic [ADDR_W-1:0]     ptr_q;
   logic                  oe_q;
   logic                  sclRise;
   logic                  sclFall;
   logic                  startCond;
   logic                  stopCond;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sclQ <= 1'b1;
         sdaQ <= 1'b1;
      end else begin
         sclQ <= sclIn;
         sdaQ <= sdaIn;
      end
   end

   assign sclRise   = sclIn && !sclQ;
   assign sclFall   = !sclIn && sclQ;
   assign startCond = sclIn && sclQ && sdaQ && !sdaIn;
   assign stopCond  = sclIn && sclQ && !sdaQ && sdaIn;

   // byte state; open drain so only a low is ever driven
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= I2C_IDLE;
         shift_q    <= '0;
         tx_q       <= '0;
         cnt_q      <= '0;
         byteDone_q <= 1'b0;
         rw_q       <= 1'b0;
         wrSeen_q   <= 1'b0;
         mAck_q     <= 1'b0;
         ptr_q      <= '0;
         oe_q       <= 1'b0;
      end else if (startCond) begin
         state_q    <= I2C_ADDR;
         cnt_q      <= '0;
         byteDone_q <= 1'b0;
         wrSeen_q   <= 1'b0;
         oe_q       <= 1'b0;
      end else if (stopCond) begin
         state_q <= I2C_IDLE;
         oe_q    <= 1'b0;
      end else begin
         unique case (state_q)
            I2C_IDLE: begin
               oe_q <= 1'b0;
            end
            I2C_ADDR, I2C_PTR: begin
               if (sclRise) begin
                  shift_q    <= {shift_q[DATA_W-2:0], sdaIn};
                  cnt_q      <= cnt_q + 3'h1;
                  byteDone_q <= (cnt_q == 3'h7);
               end else if (sclFall && byteDone_q) begin
                  byteDone_q <= 1'b0;
                  if (state_q == I2C_ADDR) begin
                     if (shift_q[7:1] == TARGET_ADDR) begin
                        oe_q    <= 1'b1;
                        rw_q    <= shift_q[0];
                        state_q <= I2C_AACK;
                     end else begin
                        state_q <= I2C_IDLE;
                     end
                  end else begin
                     // only the first written byte moves the pointer
                     if (!wrSeen_q) begin
                        ptr_q <= shift_q;
                     end
                     wrSeen_q <= 1'b1;
                     oe_q     <= 1'b1;
                     state_q  <= I2C_PACK;
                  end
               end
            end
            I2C_AACK, I2C_PACK: begin
               if (sclFall) begin
                  cnt_q <= '0;
                  if (state_q == I2C_AACK && rw_q) begin
                     tx_q    <= rdData;
                     oe_q    <= !rdData[DATA_W-1];
                     state_q <= I2C_TX;
                  end else begin
                     oe_q    <= 1'b0;
                     state_q <= I2C_PTR;
                  end
               end
            end
            I2C_TX: begin
               if (sclFall) begin
                  if (cnt_q == 3'h7) begin
                     oe_q    <= 1'b0;
                     ptr_q   <= ptr_q + 8'h01;
                     state_q <= I2C_MACK;
                  end else begin
                     cnt_q <= cnt_q + 3'h1;
                     tx_q  <= {tx_q[DATA_W-2:0], 1'b0};
                     oe_q  <= !tx_q[DATA_W-2];
                  end
               end
            end
            I2C_MACK: begin
               if (sclRise) begin
                  mAck_q <= !sdaIn;
               end else if (sclFall) begin
                  cnt_q <= '0;
                  if (mAck_q) begin
                     tx_q    <= rdData;
                     oe_q    <= !rdData[DATA_W-1];
                     state_q <= I2C_TX;
                  end else begin
                     state_q <= I2C_IDLE;
                  end
               end
            end
            default: begin
               state_q <= I2C_IDLE;
               oe_q    <= 1'b0;
            end
         endcase
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe  = oe_q;
   assign rdAddr = ptr_q;

   addr_ack_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      state_q == I2C_ADDR && byteDone_q && sclFall
      && shift_q[7:1] == TARGET_ADDR |=> sdaOe && state_q == I2C_AACK)
      else $error("own address not acknowledged");
   sda_timing_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $changed(sdaOe) |-> $past(sclFall || startCond || stopCond))
      else $error("data line changed while clock high");
endmodule : oms_i2c_target

// >>> core/oms_mgmt_status.sv
`timescale 1ns/1ps
module oms_mgmt_status #(
   parameter int         INIT_CYCLES = oms_pkg::INIT_CYC,
   parameter logic [6:0] TARGET_ADDR = oms_pkg::TARGET_ADDR
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst_b,
   input  wire logic                       txShutoff,
   input  wire logic                       laserFaultDet,
   input  wire logic                       rxSignalOk,
   input  wire logic [oms_pkg::MON_W-1:0]  tempRaw,
   input  wire logic [oms_pkg::MON_W-1:0]  vccRaw,
   input  wire logic [oms_pkg::MON_W-1:0]  biasRaw,
   input  wire logic [oms_pkg::MON_W-1:0]  txPwrRaw,
   input  wire logic [oms_pkg::MON_W-1:0]  rxPwrRaw,
   input  wire logic                       sclIn,
   input  wire logic                       sdaIn,
   output logic                            sdaOut,
   output logic                            sdaOe,
   output logic                            laserEnable,
   output logic                            txFaultOut,
   output logic                            txFaultOe,
   output logic                            signalLostFlagOut,
   output logic                            signalLostFlagOe,
   output logic                            presenceOut,
   output logic                            presenceOe,
   output logic                            initDone
);
   import oms_pkg::*;

   logic [31:0]                 initCnt_q;
   logic                        initDone_q;
   logic                        fault_q;
   logic [RST_CNT_W-1:0]        holdCnt_q;
   logic                        laserOn_q;
   logic                        signalLostFlag_q;
   logic [MON_W-1:0]            monRaw [NUM_MON];
   logic [MON_W-1:0]            raw_q  [NUM_MON];
   logic [MON_W-1:0]            cal_q  [NUM_MON];
   logic [ADDR_W-1:0]           rdAddr;
   logic [DATA_W-1:0]           rdData;
   logic [DATA_W-1:0]           statusByte;

   assign monRaw[0] = tempRaw;
   assign monRaw[1] = vccRaw;
   assign monRaw[2] = biasRaw;
   assign monRaw[3] = txPwrRaw;
   assign monRaw[4] = rxPwrRaw;

   // power-up interval: laser dark and fault cleared until it ends
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         initCnt_q  <= '0;
         initDone_q <= 1'b0;
      end else if (!initDone_q) begin
         initCnt_q  <= initCnt_q + 32'h1;
         initDone_q <= (initCnt_q == 32'(INIT_CYCLES - 1));
      end
   end

   // shutoff held high for the reset time rearms a latched fault
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         holdCnt_q <= '0;
      end else if (!txShutoff) begin
         holdCnt_q <= '0;
      end else if (holdCnt_q != RST_CNT_W'(RESET_CYC)) begin
         holdCnt_q <= holdCnt_q + {{(RST_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // fault is sticky; a live fault wins over the shutoff clear, but the power-up interval clears it regardless
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_q <= 1'b0;
      end else if (!initDone_q) begin
         fault_q <= 1'b0;
      end else if (laserFaultDet) begin
         fault_q <= 1'b1;
      end else if (holdCnt_q == RST_CNT_W'(RESET_CYC)) begin
         fault_q <= 1'b0;
      end
   end

   // one cycle reaction is far inside both the off and on limits
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         laserOn_q <= 1'b0;
      end else begin
         laserOn_q <= initDone_q && !txShutoff && !fault_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         signalLostFlag_q <= 1'b1;
      end else begin
         signalLostFlag_q <= !rxSignalOk;
      end
   end

   // snapshot raw samples and apply internal slope and offset
   for (genvar i = 0; i < NUM_MON; i++) begin : g_mon
      logic [2*MON_W-1:0] prod;
      assign prod = raw_q[i] * CAL_SLOPE[i];
      always_ff @(posedge core_clk or negedge rst_b) begin
         if (!rst_b) begin
            raw_q[i] <= '0;
            cal_q[i] <= '0;
         end else begin
            raw_q[i] <= monRaw[i];
            cal_q[i] <= prod[CAL_SHIFT +: MON_W] + CAL_OFFSET[i];
         end
      end
   end

   always_comb begin
      statusByte               = '0;
      statusByte[ST_FAULT_BIT] = fault_q;
      statusByte[ST_LOST_BIT]  = signalLostFlag_q;
      statusByte[ST_TXON_BIT]  = laserOn_q;
      statusByte[ST_INIT_BIT]  = initDone_q;
   end

   // read map: id bytes, calibrated, raw plus coefficients, status
   always_comb begin
      rdData = '0;
      if (rdAddr < ADDR_W'(ID_LEN)) begin
         rdData = ID_ROM[rdAddr[3:0]];
      end else if (rdAddr == STATUS_ADDR) begin
         rdData = statusByte;
      end
      for (int i = 0; i < NUM_MON; i++) begin
         if (rdAddr == CAL_BASE + ADDR_W'(2 * i)) begin
            rdData = cal_q[i][15:8];
         end
         if (rdAddr == CAL_BASE + ADDR_W'(2 * i + 1)) begin
            rdData = cal_q[i][7:0];
         end
         if (rdAddr == RAW_BASE + ADDR_W'(2 * i)) begin
            rdData = raw_q[i][15:8];
         end
         if (rdAddr == RAW_BASE + ADDR_W'(2 * i + 1)) begin
            rdData = raw_q[i][7:0];
         end
         if (rdAddr == COEF_BASE + ADDR_W'(4 * i)) begin
            rdData = CAL_SLOPE[i][15:8];
         end
         if (rdAddr == COEF_BASE + ADDR_W'(4 * i + 1)) begin
            rdData = CAL_SLOPE[i][7:0];
         end
         if (rdAddr == COEF_BASE + ADDR_W'(4 * i + 2)) begin
            rdData = CAL_OFFSET[i][15:8];
         end
         if (rdAddr == COEF_BASE + ADDR_W'(4 * i + 3)) begin
            rdData = CAL_OFFSET[i][7:0];
         end
      end
   end

   // host must keep the serial clock under its limit; not checked here
   oms_i2c_target #(
      .TARGET_ADDR (TARGET_ADDR)
   ) u_target (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .sclIn    (sclIn),
      .sdaIn    (sdaIn),
      .sdaOut   (sdaOut),
      .sdaOe    (sdaOe),
      .rdAddr   (rdAddr),
      .rdData   (rdData)
   );

   assign laserEnable       = laserOn_q;
   // open collector pins: pulling low means logic 0 at the host
   assign txFaultOut        = 1'b0;
   assign txFaultOe         = !fault_q;
   assign signalLostFlagOut = 1'b0;
   assign signalLostFlagOe  = !signalLostFlag_q;
   assign presenceOut       = 1'b0;
   assign presenceOe        = 1'b1;
   assign initDone          = initDone_q;

   fault_pin_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      txFaultOe == !fault_q
      && (!fault_q || $past(fault_q || laserFaultDet)))
      else $error("fault pin does not follow fault state");
   light_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      laserEnable |-> $past(!txShutoff && initDone_q))
      else $error("light emitted without shutoff low");
   presence_pin_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      presenceOe && !presenceOut)
      else $error("presence pin not grounded");
   lost_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !rxSignalOk ##1 1'b1 |-> signalLostFlagOut == 1'b0 && !signalLostFlagOe)
      else $error("signal lost not reported");
   diag_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      rdAddr == RAW_BASE |=> $past(rdData) == $past(raw_q[0][15:8])
      && raw_q[0] == $past(tempRaw))
      else $error("raw temperature not readable");
   int_cal_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 cal_q[1] == MON_W'((32'($past(raw_q[1])) * 32'(CAL_SLOPE[1]))
      >> CAL_SHIFT) + CAL_OFFSET[1])
      else $error("internal calibration wrong");
   fault_time_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      laserFaultDet && initDone_q |-> ##[1:2] !txFaultOe)
      else $error("fault not raised in time");
   off_time_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(txShutoff) |=> !laserEnable [*2])
      else $error("transmitter not off after shutoff");
   on_time_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !txShutoff && initDone_q && !fault_q && !laserFaultDet |=> laserEnable)
      else $error("transmitter not restored");
   init_time_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !initDone_q |-> initCnt_q < 32'(INIT_CYCLES) && !fault_q && !laserEnable)
      else $error("initialisation overran or not dark");
endmodule : oms_mgmt_status

// >>> dv/oms_host_model.sv
`timescale 1ns/1ps
module oms_host_model #(
   parameter int HALF = 13
) (
   input  wire logic core_clk,
   input  wire logic sdaLine,
   output logic      sclOe,
   output logic      sdaOe
);
   // 27 core cycles per bit is about 370 kHz, under the ceiling
   initial begin
      sclOe = 1'b0;
      sdaOe = 1'b0;
   end

   task automatic halfBit();
      repeat (HALF) @(posedge core_clk);
   endtask : halfBit

   task automatic putBit(input logic b);
      @(posedge core_clk) sdaOe <= ~b;
      halfBit();
      sclOe <= 1'b0;
      halfBit();
      sclOe <= 1'b1;
   endtask : putBit

   // data is taken late in the high phase, where the target holds it
   task automatic getBit(output logic b);
      @(posedge core_clk) sdaOe <= 1'b0;
      halfBit();
      sclOe <= 1'b0;
      halfBit();
      b = sdaLine;
      sclOe <= 1'b1;
   endtask : getBit

   task automatic startCond();
      @(posedge core_clk) sdaOe <= 1'b0;
      halfBit();
      sclOe <= 1'b0;
      halfBit();
      sdaOe <= 1'b1;
      halfBit();
      sclOe <= 1'b1;
   endtask : startCond

   task automatic stopCond();
      @(posedge core_clk) sdaOe <= 1'b1;
      halfBit();
      sclOe <= 1'b0;
      halfBit();
      sdaOe <= 1'b0;
      halfBit();
   endtask : stopCond

   task automatic writeByte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) putBit(v[i]);
      getBit(b);
      ack = ~b;
   endtask : writeByte

   task automatic readByte(output logic [7:0] v, input logic more);
      for (int i = 7; i >= 0; i--) getBit(v[i]);
      putBit(~more);
   endtask : readByte
endmodule : oms_host_model

// >>> dv/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin nMismatch++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   import oms_pkg::*;
   localparam int INIT_SIM = 20;
   localparam logic [MON_W-1:0] RAWS [NUM_MON] = '{
      16'h1A2B, 16'h8001, 16'h00FF, 16'hFFFF, 16'h4C3D};
   logic             core_clk      = 1'b0;
   logic             rst_b         = 1'b0;
   logic             txShutoff     = 1'b1;
   logic             laserFaultDet = 1'b0;
   logic             rxSignalOk    = 1'b1;
   logic [MON_W-1:0] rawV [NUM_MON] = '{default: 16'h0000};
   logic             hSclOe, hSdaOe, dSdaOut, dSdaOe, laserEnable;
   logic             txFaultOut, txFaultOe, lostOut, lostOe;
   logic             presOut, presOe, initDone;
   logic [7:0]       rdBuf [16];
   int               nMismatch = 0;
   int               nTests    = 0;
   wire              sclLine  = ~hSclOe;
   wire              sdaLine  = ~(hSdaOe | (dSdaOe & ~dSdaOut));
   wire              faultPin = txFaultOe ? txFaultOut : 1'b1;
   wire              lostPin  = lostOe ? lostOut : 1'b1;
   wire              presPin  = presOe ? presOut : 1'b1;

   always #50 core_clk = ~core_clk;

   oms_mgmt_status #(.INIT_CYCLES(INIT_SIM)) oms_mgmt_status_inst (
      .core_clk(core_clk), .rst_b(rst_b), .txShutoff(txShutoff),
      .laserFaultDet(laserFaultDet), .rxSignalOk(rxSignalOk),
      .tempRaw(rawV[0]), .vccRaw(rawV[1]), .biasRaw(rawV[2]),
      .txPwrRaw(rawV[3]), .rxPwrRaw(rawV[4]), .sclIn(sclLine),
      .sdaIn(sdaLine), .sdaOut(dSdaOut), .sdaOe(dSdaOe),
      .laserEnable(laserEnable), .txFaultOut(txFaultOut),
      .txFaultOe(txFaultOe), .signalLostFlagOut(lostOut),
      .signalLostFlagOe(lostOe), .presenceOut(presOut),
      .presenceOe(presOe), .initDone(initDone));

   oms_host_model oms_host_model_inst (
      .core_clk(core_clk), .sdaLine(sdaLine), .sclOe(hSclOe),
      .sdaOe(hSdaOe));

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle

   // pointer write, repeated start, then n reads with the last one refused
   task automatic rdSeq(input logic [7:0] ptr, input int n);
      logic ack;
      oms_host_model_inst.startCond();
      oms_host_model_inst.writeByte({TARGET_ADDR, 1'b0}, ack);
      `CHK(ack, 1'b1)
      oms_host_model_inst.writeByte(ptr, ack);
      `CHK(ack, 1'b1)
      oms_host_model_inst.startCond();
      oms_host_model_inst.writeByte({TARGET_ADDR, 1'b1}, ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < n; i++) begin
         oms_host_model_inst.readByte(rdBuf[i], i < n - 1);
      end
      oms_host_model_inst.stopCond();
   endtask : rdSeq

   task automatic doReset();
      @(posedge core_clk) rst_b <= 1'b0;
      settle(20);
      `CHK(presPin, 1'b0)
      `CHK(lostPin, 1'b1)
      `CHK(faultPin, 1'b0)
      `CHK(laserEnable, 1'b0)
      @(posedge core_clk) rst_b <= 1'b1;
      settle(INIT_SIM - 2);
      `CHK(initDone, 1'b0)
      `CHK(laserEnable, 1'b0)
      settle(4);
      `CHK(initDone, 1'b1)
      $display("reset and initialisation done");
   endtask : doReset

   task automatic testLaser();
      settle(3);
      `CHK(laserEnable, 1'b0)
      @(posedge core_clk) txShutoff <= 1'b0;
      settle(3);
      `CHK(laserEnable, 1'b1)
      @(posedge core_clk) txShutoff <= 1'b1;
      settle(3);
      `CHK(laserEnable, 1'b0)
      $display("shutoff test done");
   endtask : testLaser

   // a short shutoff pulse must not clear the latch; a long one must
   task automatic testFault();
      @(posedge core_clk) txShutoff <= 1'b0;
      laserFaultDet <= 1'b1;
      settle(3);
      `CHK(faultPin, 1'b1)
      `CHK(laserEnable, 1'b0)
      @(posedge core_clk) laserFaultDet <= 1'b0;
      settle(10);
      `CHK(faultPin, 1'b1)
      @(posedge core_clk) txShutoff <= 1'b1;
      settle(50);
      @(posedge core_clk) txShutoff <= 1'b0;
      settle(3);
      `CHK(faultPin, 1'b1)
      `CHK(laserEnable, 1'b0)
      @(posedge core_clk) txShutoff <= 1'b1;
      settle(105);
      `CHK(faultPin, 1'b0)
      @(posedge core_clk) txShutoff <= 1'b0;
      settle(3);
      `CHK(laserEnable, 1'b1)
      @(posedge core_clk) laserFaultDet <= 1'b1;
      settle(3);
      `CHK(faultPin, 1'b1)
      @(posedge core_clk) laserFaultDet <= 1'b0;
      doReset();
      settle(3);
      `CHK(laserEnable, 1'b1)
      @(posedge core_clk) txShutoff <= 1'b1;
      settle(3);
      $display("fault test done");
   endtask : testFault

   task automatic testLost();
      `CHK(lostPin, 1'b0)
      @(posedge core_clk) rxSignalOk <= 1'b0;
      settle(3);
      `CHK(lostPin, 1'b1)
      @(posedge core_clk) rxSignalOk <= 1'b1;
      settle(3);
      `CHK(lostPin, 1'b0)
      $display("signal lost test done");
   endtask : testLost

   // runs off the end of the identification area into unmapped space
   task automatic testId();
      rdSeq(8'h0C, 5);
      for (int i = 0; i < 4; i++) begin
         `CHK(rdBuf[i], ID_ROM[12 + i])
      end
      `CHK(rdBuf[4], 8'h00)
      $display("identification test done");
   endtask : testId

   task automatic testDiag();
      logic [31:0]      prod;
      logic [MON_W-1:0] calE;
      for (int i = 0; i < NUM_MON; i++) begin
         @(posedge core_clk) rawV[i] <= RAWS[i];
      end
      settle(4);
      rdSeq(RAW_BASE, 2 * NUM_MON);
      for (int i = 0; i < NUM_MON; i++) begin
         `CHK({rdBuf[2 * i], rdBuf[2 * i + 1]}, RAWS[i])
      end
      rdSeq(CAL_BASE, 2 * NUM_MON);
      for (int i = 0; i < NUM_MON; i++) begin
         prod = 32'(RAWS[i]) * 32'(CAL_SLOPE[i]);
         calE = prod[23:8] + CAL_OFFSET[i];
         `CHK({rdBuf[2 * i], rdBuf[2 * i + 1]}, calE)
      end
      rdSeq(COEF_BASE, 4);
      `CHK({rdBuf[0], rdBuf[1]}, CAL_SLOPE[0])
      `CHK({rdBuf[2], rdBuf[3]}, CAL_OFFSET[0])
      $display("diagnostics test done");
   endtask : testDiag

   task automatic testAddr();
      logic ack;
      oms_host_model_inst.startCond();
      oms_host_model_inst.writeByte({TARGET_ADDR ^ 7'h01, 1'b1}, ack);
      `CHK(ack, 1'b0)
      oms_host_model_inst.stopCond();
      @(posedge core_clk) rxSignalOk <= 1'b0;
      rdSeq(STATUS_ADDR, 1);
      `CHK(rdBuf[0], 8'((1 << ST_INIT_BIT) | (1 << ST_LOST_BIT)))
      @(posedge core_clk) rxSignalOk <= 1'b1;
      $display("address test done");
   endtask : testAddr

   initial begin
      doReset();
      testLaser();
      testFault();
      testLost();
      testId();
      testDiag();
      testAddr();
      conclude();
   end

   // the whole run needs about 12000 cycles
   initial begin
      repeat (40000) @(posedge core_clk);
      nMismatch++;
      conclude();
   end
endmodule : tb
